// File: design/etdi_pkg.sv
// constants, field layouts and types shared by the edge interrupt block
package etdi_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESET = 8'h04;
    localparam logic [7:0] ADDR_ELAPSED = 8'h08;
    localparam logic [7:0] ADDR_OPERAND = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_ROUTINE = 8'h1c;

    localparam int NUM_SOURCES = 8;
    localparam int SEL_W = 3;
    localparam int NUM_RESULTS = 4;

    // delay step and clock rate
    localparam int STEP_MS = 10;
    localparam int CLK_KHZ = 125000;
    localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;
    localparam logic [31:0] STEP_MS_W = 32'h0000000a;

    localparam logic [1:0] MODE_RISE = 2'h0;
    localparam logic [1:0] MODE_FALL = 2'h1;
    localparam logic [1:0] MODE_BOTH = 2'h2;

    localparam int ST_LAUNCH = 0;
    localparam int ST_MISSED = 1;
    localparam int ST_DONE = 2;
    localparam int STATUS_W = 3;
    localparam int ROUTINE_DONE_BIT = 0;
    localparam int ROUTINE_RUN_BIT = 0;
    localparam int ROUTINE_DELAY_BIT = 1;

    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] PRESET_RESET = 32'h00000000;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 3'h0;
    localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;

    typedef struct packed {
        logic [20:0] rsvd_hi;
        logic [2:0] src_sel;
        logic [2:0] rsvd_mid;
        logic delay_reload;
        logic enable;
        logic release_on;
        logic [1:0] mode;
    } etdi_ctrl_type;

    typedef struct packed {
        logic rise;
        logic fall;
    } etdi_edge_type;

    typedef enum logic [1:0] {S_IDLE, S_DELAY, S_RUN} etdi_state_type;
endpackage

// File: design/etdi_edge_sel.sv
// input synchroniser and edge detector for the selected source line
`timescale 1ns/100ps
module etdi_edge_sel
    import etdi_pkg::*;
#(
    parameter int N = NUM_SOURCES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] source_in,
    input wire logic [SEL_W-1:0] src_sel,
    output etdi_edge_type edges
);
    logic [N-1:0] sync1_reg, sync2_reg, prev_reg;
    logic [N-1:0] sync1_next, sync2_next, prev_next;

    always_comb begin
        sync1_next = source_in;
        sync2_next = sync1_reg;
        prev_next = sync2_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
        end
    end

    // every line is tracked, so a change of selection gives no false edge
    always_comb begin
        edges.rise = sync2_reg[src_sel] & ~prev_reg[src_sel];
        edges.fall = ~sync2_reg[src_sel] & prev_reg[src_sel];
    end
endmodule

// File: design/etdi_delay_timer.sv
// delay counter that steps in 10 ms units and reports elapsed time
`timescale 1ns/100ps
module etdi_delay_timer
    import etdi_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic run,
    input wire logic reload,
    input wire logic [31:0] preset,
    output logic expired,
    output logic [31:0] elapsed
);
    logic [31:0] presc_reg, presc_next;
    logic [31:0] remain_reg, remain_next;
    logic [31:0] elapsed_reg, elapsed_next;
    logic expired_reg, expired_next;

    always_comb begin
        presc_next = presc_reg;
        remain_next = remain_reg;
        elapsed_next = elapsed_reg;
        expired_next = 1'b0;
        if (start || (reload && run)) begin
            remain_next = preset;
            elapsed_next = '0;
            presc_next = '0;
        end else if (run) begin
            if (presc_reg == 32'(STEP_CYC - 1)) begin
                presc_next = '0;
                elapsed_next = elapsed_reg + STEP_MS_W;
                if (remain_reg <= STEP_MS_W) begin
                    remain_next = '0;
                    expired_next = 1'b1;
                end else begin
                    remain_next = remain_reg - STEP_MS_W;
                end
            end else begin
                presc_next = presc_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= '0;
            remain_reg <= '0;
            elapsed_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            remain_reg <= remain_next;
            elapsed_reg <= elapsed_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;
    assign elapsed = elapsed_reg;
endmodule

// File: design/etdi_top.sv
// edge-triggered delayed interrupt block with apb register access
`timescale 1ns/100ps

// What this block does
// - in rising-edge mode a low-to-high change of the selected input launches the routine once after the delay.
// - in falling-edge mode a high-to-low change of the selected input launches the routine once after the delay.
// - in both-edges mode a change of either direction while idle launches one run of the routine after the delay.
// - four result bits set by the routine appear as the block's bit outputs.
// - a 32-bit output shows the delay time elapsed since the triggering edge.
// - with enable release on, the block acts on the enable bit and, unless the routine is already running, goes or stays idle while it is low.
// - with enable release off, the block is always enabled and the enable bit does nothing.
// - while delay reload is high during the delay count, the delay counter is loaded again from the preset.
// - edges arriving while the routine runs or the delay counts are ignored.
// - with no delay set, the first qualifying edge on the chosen one of eight inputs launches at once.
module etdi_top
    import etdi_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SOURCES-1:0] source_in,
    output logic result_bit_one,
    output logic result_bit_two,
    output logic result_bit_three,
    output logic result_bit_four,
    output logic [31:0] elapsed_delay_value,
    output logic routine_active,
    output logic irq
);
    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            ADDR_CTRL, ADDR_PRESET, ADDR_ELAPSED, ADDR_OPERAND,
            ADDR_RESULT, ADDR_STATUS, ADDR_MASK, ADDR_ROUTINE: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    etdi_ctrl_type ctrl_reg, ctrl_next;
    logic [31:0] preset_reg, preset_next;
    logic [NUM_RESULTS-1:0] operand_reg, operand_next;
    logic [NUM_RESULTS-1:0] result_reg, result_next;
    logic [STATUS_W-1:0] status_reg, status_next;
    logic [STATUS_W-1:0] mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    etdi_state_type state_reg, state_next;

    etdi_edge_type edges;
    logic wr_en, setup;
    logic active, qualify, launch, start_delay, done_write, missed;
    logic expired;
    logic [31:0] elapsed;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign done_write = wr_en && (paddr == ADDR_ROUTINE) && pwdata[ROUTINE_DONE_BIT];

    etdi_edge_sel #(
        .N(NUM_SOURCES)
    ) u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .source_in(source_in),
        .src_sel(ctrl_reg.src_sel),
        .edges(edges)
    );

    etdi_delay_timer #(
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_delay),
        .run(state_reg == S_DELAY),
        .reload(ctrl_reg.delay_reload),
        .preset(preset_reg),
        .expired(expired),
        .elapsed(elapsed)
    );

    // block enable and edge qualification
    always_comb begin
        active = ctrl_reg.release_on ? ctrl_reg.enable : 1'b1;
        case (ctrl_reg.mode)
            MODE_RISE: qualify = edges.rise;
            MODE_FALL: qualify = edges.fall;
            MODE_BOTH: qualify = edges.rise | edges.fall;
            default: qualify = edges.rise;
        endcase
    end

    // sequencer: idle, delay counting, routine running
    always_comb begin
        state_next = state_reg;
        launch = 1'b0;
        start_delay = 1'b0;
        missed = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (active && qualify) begin
                    start_delay = 1'b1;
                    if (preset_reg == 32'h00000000) begin
                        launch = 1'b1;
                        state_next = S_RUN;
                    end else begin
                        state_next = S_DELAY;
                    end
                end
            end
            S_DELAY: begin
                missed = qualify;
                if (!active) begin
                    state_next = S_IDLE;
                end else if (expired && !ctrl_reg.delay_reload) begin
                    launch = 1'b1;
                    state_next = S_RUN;
                end
            end
            S_RUN: begin
                missed = qualify;
                if (done_write) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // register file writes and sticky status, set beats clear
    always_comb begin
        ctrl_next = ctrl_reg;
        preset_next = preset_reg;
        operand_next = operand_reg;
        result_next = result_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        if (wr_en) begin
            case (paddr)
                ADDR_CTRL: ctrl_next = etdi_ctrl_type'(pwdata);
                ADDR_PRESET: preset_next = pwdata;
                ADDR_OPERAND: operand_next = pwdata[NUM_RESULTS-1:0];
                ADDR_RESULT: result_next = pwdata[NUM_RESULTS-1:0];
                ADDR_MASK: mask_next = pwdata[STATUS_W-1:0];
                ADDR_STATUS: status_next = status_reg & ~pwdata[STATUS_W-1:0];
                default: ;
            endcase
        end
        ctrl_next.rsvd_hi = '0;
        ctrl_next.rsvd_mid = '0;
        if (launch) begin
            status_next[ST_LAUNCH] = 1'b1;
        end
        if (missed) begin
            status_next[ST_MISSED] = 1'b1;
        end
        if (done_write && state_reg == S_RUN) begin
            status_next[ST_DONE] = 1'b1;
        end
    end

    // read data and error captured in the setup cycle
    always_comb begin
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup) begin
            pslverr_next = !addr_known(paddr);
            case (paddr)
                ADDR_CTRL: prdata_next = ctrl_reg;
                ADDR_PRESET: prdata_next = preset_reg;
                ADDR_ELAPSED: prdata_next = elapsed;
                ADDR_OPERAND: prdata_next = {28'h0000000, operand_reg};
                ADDR_RESULT: prdata_next = {28'h0000000, result_reg};
                ADDR_STATUS: prdata_next = {29'h00000000, status_reg};
                ADDR_MASK: prdata_next = {29'h00000000, mask_reg};
                ADDR_ROUTINE: prdata_next = {30'h00000000, state_reg == S_DELAY, state_reg == S_RUN};
                default: prdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= etdi_ctrl_type'(CTRL_RESET);
            preset_reg <= PRESET_RESET;
            operand_reg <= '0;
            result_reg <= '0;
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            state_reg <= S_IDLE;
        end else begin
            ctrl_reg <= ctrl_next;
            preset_reg <= preset_next;
            operand_reg <= operand_next;
            result_reg <= result_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            state_reg <= state_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign result_bit_one = result_reg[0];
    assign result_bit_two = result_reg[1];
    assign result_bit_three = result_reg[2];
    assign result_bit_four = result_reg[3];
    assign elapsed_delay_value = elapsed;
    assign routine_active = (state_reg == S_RUN);
    assign irq = |(status_reg & mask_reg);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rise_no_delay_a: assert property (
        state_reg == S_IDLE && active && ctrl_reg.mode == MODE_RISE && edges.rise && preset_reg == 32'h0
        |=> state_reg == S_RUN && status_reg[ST_LAUNCH])
        else $error("rising edge did not launch the routine");

    fall_no_delay_a: assert property (
        state_reg == S_IDLE && active && ctrl_reg.mode == MODE_FALL && edges.fall && preset_reg == 32'h0
        |=> state_reg == S_RUN)
        else $error("falling edge did not launch the routine");

    fall_ignores_rise_a: assert property (
        state_reg == S_IDLE && ctrl_reg.mode == MODE_FALL && edges.rise |=> state_reg == S_IDLE)
        else $error("rising edge acted in falling mode");

    both_edges_delay_a: assert property (
        state_reg == S_IDLE && active && ctrl_reg.mode == MODE_BOTH && (edges.rise || edges.fall)
        && preset_reg != 32'h0 |=> state_reg == S_DELAY ##1 elapsed == 32'h0)
        else $error("edge in both mode did not start the delay");

    result_output_a: assert property (
        wr_en && paddr == ADDR_RESULT |=> result_bit_four == $past(pwdata[3]) && result_bit_one == $past(pwdata[0]))
        else $error("result bits do not follow the routine write");

    elapsed_hold_a: assert property (
        state_reg == S_RUN && $past(state_reg) == S_RUN |-> $stable(elapsed_delay_value))
        else $error("elapsed value moved while routine ran");

    elapsed_step_a: assert property (
        state_reg == S_DELAY && !ctrl_reg.delay_reload && active && !expired |=>
        elapsed == $past(elapsed) || elapsed == $past(elapsed) + STEP_MS_W)
        else $error("elapsed value stepped by a wrong amount");

    enable_gate_a: assert property (
        ctrl_reg.release_on && !ctrl_reg.enable && state_reg != S_RUN |=> state_reg == S_IDLE)
        else $error("block acted while enable was low");

    enable_ignored_a: assert property (
        !ctrl_reg.release_on && state_reg == S_IDLE && qualify && preset_reg == 32'h0 |=> state_reg == S_RUN)
        else $error("enable bit was not ignored");

    reload_counter_a: assert property (
        state_reg == S_DELAY && ctrl_reg.delay_reload && active |=> elapsed == 32'h0 && state_reg == S_DELAY)
        else $error("reload did not restart the delay");

    busy_ignore_a: assert property (
        state_reg == S_RUN && qualify && !done_write |=> state_reg == S_RUN && status_reg[ST_MISSED])
        else $error("edge during routine was not ignored");

    no_delay_elapsed_a: assert property (
        state_reg == S_IDLE && active && qualify && preset_reg == 32'h0
        |=> state_reg == S_RUN && elapsed_delay_value == 32'h0)
        else $error("edge without delay did not launch at once");

    delay_busy_a: assert property (
        state_reg == S_DELAY && active && qualify && !expired
        |=> state_reg == S_DELAY && status_reg[ST_MISSED])
        else $error("edge during delay was not ignored");

    elapsed_start_a: assert property (
        state_reg == S_DELAY && $past(state_reg) == S_IDLE
        |-> elapsed_delay_value == 32'h0)
        else $error("elapsed value did not start from zero");

    delay_launch_a: assert property (
        state_reg == S_DELAY && active && expired && !ctrl_reg.delay_reload
        |=> state_reg == S_RUN && status_reg[ST_LAUNCH])
        else $error("expired delay did not launch the routine");

    reload_no_launch_a: assert property (
        state_reg == S_DELAY && ctrl_reg.delay_reload
        |=> state_reg != S_RUN)
        else $error("routine launched while the delay reloaded");

    mode_three_rise_a: assert property (
        state_reg == S_IDLE && ctrl_reg.mode == 2'h3 && edges.fall
        |=> state_reg == S_IDLE)
        else $error("falling edge acted in the spare rising mode");
endmodule

// File: bench/etdi_field_model.sv
// field input line model driving the eight source lines
`timescale 1ns/100ps
module etdi_field_model (
    input wire logic pclk,
    output logic [7:0] source_in
);
    initial source_in = 8'h00;
    // a line changes just after a clock edge and holds until the next request
    task automatic drive(input logic [2:0] sel, input logic val);
        @(posedge pclk);
        source_in[sel] <= val;
    endtask
endmodule

// File: bench/test_edge_triggered_delayed_interrupt.sv
// self-checking bench for the edge interrupt block
`timescale 1ns/100ps
module test_edge_triggered_delayed_interrupt;
    import etdi_pkg::*;
    localparam int SC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic rb1, rb2, rb3, rb4, routine_active, irq, s;
    logic [7:0] paddr, source_in;
    logic [31:0] pwdata, prdata, elapsed_delay_value, rd, p;
    logic [2:0] sel;
    int mismatches, cmp_count, seed, n;
    etdi_top #(.STEP_CYC(SC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .source_in(source_in), .result_bit_one(rb1), .result_bit_two(rb2),
        .result_bit_three(rb3), .result_bit_four(rb4), .elapsed_delay_value(elapsed_delay_value),
        .routine_active(routine_active), .irq(irq));
    etdi_field_model field_u (.pclk(pclk), .source_in(source_in));
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    function automatic logic [31:0] ctrl(int m, logic rel, logic en, logic rl, logic [2:0] sl);
        return {21'h0, sl, 3'h0, rl, en, rel, m[1:0]};
    endfunction
    function automatic logic [31:0] exp_el(logic [31:0] pr);
        return ((pr + 32'h9) / 32'ha) * 32'ha;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask
    task automatic end_routine;
        apb(1, ADDR_ROUTINE, 32'h1);
        apb(1, ADDR_STATUS, 32'h7);
        repeat (2) @(posedge pclk);
    endtask
    task automatic arm(int m, logic [2:0] sl, logic lvl);
        apb(1, ADDR_CTRL, ctrl(m, 1, 0, 0, sl));
        field_u.drive(sl, lvl);
        repeat (6) @(posedge pclk);
        apb(1, ADDR_CTRL, ctrl(m, 1, 1, 0, sl));
    endtask
    task automatic finish_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        seed = 32'h0b15;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        cmp_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CTRL, 0);
        chk(rd, CTRL_RESET, "ctrl reset");
        apb(0, ADDR_ELAPSED, 0);
        chk(rd, 32'h0, "elapsed reset");
        apb(0, 8'h20, 0);
        chkb(err, 1'b1, "unmapped error");
        apb(1, ADDR_MASK, 32'h1);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            sel = 3'($random(seed));
            s = (m == 1) ? 1'b0 : 1'b1;
            arm(m, sel, s);
            field_u.drive(sel, ~s);
            wait_irq(12);
            chkb(irq, m == 2, "opposite edge");
            if (irq) begin
                end_routine;
            end
            field_u.drive(sel, s);
            wait_irq(12);
            chkb(irq, 1'b1, "edge launch");
            chkb(routine_active, 1'b1, "routine running");
            apb(0, ADDR_ROUTINE, 0);
            chk(rd, 32'h1, "routine flag");
            end_routine;
            wait_irq(12);
            chkb(irq, 1'b0, "single launch");
        end
        $display("test modes done");
        p = 32'd40 + 32'd10 * ($unsigned($random(seed)) % 3);
        apb(1, ADDR_PRESET, p);
        arm(MODE_BOTH, 3'h0, 1'b0);
        field_u.drive(3'h0, 1'b1);
        repeat (4) @(posedge pclk);
        field_u.drive(3'h0, 1'b0);
        repeat (4) @(posedge pclk);
        field_u.drive(3'h0, 1'b1);
        wait_irq(100);
        chkb(n + 10 >= p / 10 * SC && n <= p / 10 * SC, 1'b1, "delay length");
        chk(elapsed_delay_value, exp_el(p), "elapsed out");
        repeat (8) @(posedge pclk);
        apb(0, ADDR_ELAPSED, 0);
        chk(rd, exp_el(p), "elapsed held");
        apb(0, ADDR_STATUS, 0);
        chk(rd, 32'h3, "busy edge flagged");
        end_routine;
        wait_irq(40);
        chkb(irq, 1'b0, "no queued launch");
        $display("test delay done");
        apb(1, ADDR_CTRL, ctrl(MODE_RISE, 1, 1, 0, 3'h0));
        field_u.drive(3'h0, 1'b0);
        repeat (6) @(posedge pclk);
        field_u.drive(3'h0, 1'b1);
        repeat (6) @(posedge pclk);
        apb(1, ADDR_CTRL, ctrl(MODE_RISE, 1, 1, 1, 3'h0));
        wait_irq(60);
        chkb(irq, 1'b0, "reload holds");
        apb(1, ADDR_CTRL, ctrl(MODE_RISE, 1, 1, 0, 3'h0));
        wait_irq(60);
        chkb(irq, 1'b1, "launch after reload");
        end_routine;
        $display("test reload done");
        apb(1, ADDR_PRESET, 32'h0);
        apb(1, ADDR_CTRL, ctrl(MODE_RISE, 1, 0, 0, 3'h5));
        field_u.drive(3'h5, 1'b0);
        repeat (6) @(posedge pclk);
        field_u.drive(3'h5, 1'b1);
        wait_irq(12);
        chkb(irq, 1'b0, "enable low idle");
        apb(1, ADDR_CTRL, ctrl(MODE_RISE, 0, 0, 0, 3'h5));
        apb(1, ADDR_MASK, 32'h0);
        field_u.drive(3'h5, 1'b0);
        repeat (6) @(posedge pclk);
        field_u.drive(3'h5, 1'b1);
        wait_irq(12);
        chkb(irq, 1'b0, "masked irq");
        apb(0, ADDR_STATUS, 0);
        chk(rd & 32'h1, 32'h1, "enable ignored");
        apb(1, ADDR_MASK, 32'h1);
        wait_irq(4);
        chkb(irq, 1'b1, "unmasked irq");
        end_routine;
        chkb(irq, 1'b0, "irq cleared");
        $display("test enable done");
        for (int i = 0; i < 6; i++) begin
            p = $random(seed) & 32'hf;
            apb(1, ADDR_RESULT, p);
            repeat (2) @(posedge pclk);
            chk({28'h0, rb4, rb3, rb2, rb1}, p, "result bits");
            apb(1, ADDR_OPERAND, ~p);
            apb(0, ADDR_OPERAND, 0);
            chk(rd, ~p & 32'hf, "operand held");
        end
        $display("test results done");
        finish_test;
    end
endmodule
